// ---- sps_port.sv ----
// sps_port: byte-wide spi master/slave port behind a classic wishbone slave.
// assumes one 100 MHz clock; pins are raw and pass through sps_sync.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sps_port
    import sps_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // wishbone slave
    input  wire logic [9:0]  WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    // spi pins
    input  wire logic        SCK_I,
    output logic             SCK_O,
    output logic             SCK_OE,
    input  wire logic        MOSI_I,
    output logic             MOSI_O,
    output logic             MOSI_OE,
    input  wire logic        MISO_I,
    output logic             MISO_O,
    output logic             MISO_OE,
    input  wire logic        SS_N_I,
    // interrupt
    input  wire logic        VECTOR_ACK,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [7:0]       ctl_r;
    logic [7:0]       sr_r;
    logic [7:0]       sr_shift;
    logic [7:0]       rxbuf_r;
    logic [7:0]       rd_mux;
    logic [3:0]       pin_q;
    logic [3:0]       cnt_r;
    logic [2:0]       div_cnt_r;
    logic [2:0]       half_lim;
    logic [IRQ_W-1:0] ist_r;
    logic [IRQ_W-1:0] ien_r;
    logic [IRQ_W-1:0] ist_set;
    sps_state_e       state_r;
    logic done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, full_r;
    logic out_r, out_nxt, sck_d_r;
    logic sel_ctl, sel_sta, sel_dat, sel_ist, sel_icl, sel_ien;
    logic req, wr, rd;
    logic wr_ctl, wr_sta, wr_dat, rd_dat, wr_icl, wr_ien;
    logic port_on, controller_select, clock_idle_level, sample_edge_select, select_pin_ignore, low_bit_order;
    logic ss_q, sck_q, mosi_q, miso_q;
    logic busy, selected, slave_go, tick, m_edge, s_chg;
    logic lead_ev, trail_ev, sample_ev, launch_ev, done_ev, mode_fault_flag_evt, din;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    sps_sync #(
        .W    (4),
        .INIT (PIN_SYNC_RST)
    ) u_sync (
        .clk   (CLK),
        .rst_n (RST_N),
        .d     ({SS_N_I, SCK_I, MOSI_I, MISO_I}),
        .q     (pin_q)
    );

    assign ss_q   = pin_q[3];
    assign sck_q  = pin_q[2];
    assign mosi_q = pin_q[1];
    assign miso_q = pin_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // wishbone decode; one wait state, ack one cycle after the request
    assign req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign wr     = req & WB_WE_I & WB_SEL_I[0];
    assign rd     = req & ~WB_WE_I;
    assign wr_ctl = wr & sel_ctl;
    assign wr_sta = wr & sel_sta;
    assign wr_dat = wr & sel_dat;
    assign rd_dat = rd & sel_dat;
    assign wr_icl = wr & sel_icl;
    assign wr_ien = wr & sel_ien;

    always_comb begin
        sel_ctl = 1'b0;
        sel_sta = 1'b0;
        sel_dat = 1'b0;
        sel_ist = 1'b0;
        sel_icl = 1'b0;
        sel_ien = 1'b0;
        rd_mux  = 8'h00;
        if (WB_ADR_I[9:2] == IDX_PORT_CONTROL) begin
            sel_ctl = 1'b1;
            rd_mux  = ctl_r;
        end else if (WB_ADR_I[9:2] == IDX_PORT_STATE) begin
            sel_sta = 1'b1;
            rd_mux  = {done_r, write_collision_flag_r, mode_fault_flag_r, ovr_r, full_r, busy, 2'b00};
        end else if (WB_ADR_I[9:2] == IDX_SHIFT_DATA) begin
            sel_dat = 1'b1;
            rd_mux  = rxbuf_r;
        end else if (WB_ADR_I[9:2] == IDX_IRQ_STATUS) begin
            sel_ist = 1'b1;
            rd_mux  = {4'h0, ist_r};
        end else if (WB_ADR_I[9:2] == IDX_IRQ_CLEAR) begin
            sel_icl = 1'b1;
        end else if (WB_ADR_I[9:2] == IDX_IRQ_ENABLE) begin
            sel_ien = 1'b1;
            rd_mux  = {4'h0, ien_r};
        end
    end

    // unmapped addresses still ack, reading zero, so a master never hangs
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= req;
            if (rd) begin
                WB_DAT_O <= {24'h00_0000, rd_mux};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register
    assign port_on     = ctl_r[CTL_PORT_ON];
    assign controller_select     = ctl_r[CTL_CONTROLLER];
    assign clock_idle_level     = ctl_r[CTL_IDLE_LEVEL];
    assign sample_edge_select     = ctl_r[CTL_SAMPLE_EDGE];
    assign select_pin_ignore    = ctl_r[CTL_SELECT_IGNORE];
    assign low_bit_order     = ctl_r[CTL_LOW_BIT_ORDER];
    assign mode_fault_flag_evt = controller_select & ~select_pin_ignore & ~ss_q;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_r <= CTL_RST;
        end else if (mode_fault_flag_evt) begin
            ctl_r <= (wr_ctl ? WB_DAT_I[7:0] : ctl_r)
                     & ~(8'h01 << CTL_PORT_ON) & ~(8'h01 << CTL_CONTROLLER);
        end else if (wr_ctl) begin
            ctl_r <= WB_DAT_I[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge generation: master divider or slave edge detect
    assign half_lim = 3'((4'h1 << ctl_r[CTL_DIV_LSB +: 2]) - 4'h1);
    assign busy     = (state_r == SPS_SHIFT);
    assign tick     = (div_cnt_r == half_lim);
    assign m_edge   = controller_select & busy & tick;
    assign selected = select_pin_ignore | ~ss_q;
    assign slave_go = port_on & ~controller_select & selected;
    assign s_chg    = slave_go & (sck_q ^ sck_d_r);
    assign lead_ev  = controller_select ? (m_edge & (SCK_O == clock_idle_level)) : (s_chg & (sck_q != clock_idle_level));
    assign trail_ev = controller_select ? (m_edge & (SCK_O != clock_idle_level)) : (s_chg & (sck_q == clock_idle_level));
    assign sample_ev = sample_edge_select ? trail_ev : lead_ev;
    assign launch_ev = sample_edge_select ? lead_ev : trail_ev;
    assign din       = controller_select ? miso_q : mosi_q;
    assign sr_shift  = low_bit_order ? {din, sr_r[7:1]} : {sr_r[6:0], din};
    assign done_ev   = controller_select ? (m_edge & (cnt_r == LAST_EDGE))
                            : (sample_ev & (cnt_r == LAST_SAMPLE));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt_r <= 3'h0;
        end else if (!busy || tick) begin
            div_cnt_r <= 3'h0;
        end else begin
            div_cnt_r <= div_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sck_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer state
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= SPS_IDLE;
        end else if (!port_on) begin
            state_r <= SPS_IDLE;
        end else if (done_ev) begin
            state_r <= SPS_IDLE;
        end else if (controller_select && wr_dat && !busy) begin
            state_r <= SPS_SHIFT;
        end else if (!controller_select && !selected) begin
            state_r <= SPS_IDLE;
        end else if (!controller_select && lead_ev) begin
            state_r <= SPS_SHIFT;
        end
    end

    // master counts sck edges, slave counts samples
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= 4'h0;
        end else if (done_ev || !port_on || (controller_select && !busy) || (!controller_select && !selected)) begin
            cnt_r <= 4'h0;
        end else if (m_edge || (!controller_select && sample_ev)) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // a trailing master edge lands on idle level, so sck needs no extra fixup
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SCK_O <= 1'b0;
        end else if (!busy || !controller_select) begin
            SCK_O <= clock_idle_level;
        end else if (tick) begin
            SCK_O <= ~SCK_O;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shift register, output bit and receive buffer
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sr_r <= DAT_RST;
        end else if (wr_dat && !busy) begin
            sr_r <= WB_DAT_I[7:0];
        end else if (sample_ev) begin
            sr_r <= sr_shift;
        end
    end

    // pins take the next bit, so data moves with the launching sck edge, never with the sampling one
    assign out_nxt = (wr_dat && !busy) ? (low_bit_order ? WB_DAT_I[0] : WB_DAT_I[7])
                   : (launch_ev ? (low_bit_order ? sr_r[0] : sr_r[7]) : out_r);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
        end
    end

    // never shows sr_r mid-shift, so software sees only whole bytes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rxbuf_r <= DAT_RST;
        end else if (done_ev) begin
            rxbuf_r <= sample_ev ? sr_shift : sr_r;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SCK_OE  <= 1'b0;
            MOSI_OE <= 1'b0;
            MISO_OE <= 1'b0;
            MOSI_O  <= 1'b0;
            MISO_O  <= 1'b0;
        end else begin
            SCK_OE  <= port_on & controller_select;
            MOSI_OE <= port_on & controller_select;
            MISO_OE <= slave_go;
            MOSI_O  <= out_nxt;
            MISO_O  <= out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags; a set in the same cycle as a clear wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            done_r <= 1'b0;
        end else if (done_ev) begin
            done_r <= 1'b1;
        end else if (VECTOR_ACK || (wr_sta && !WB_DAT_I[STA_DONE])) begin
            done_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            write_collision_flag_r <= 1'b0;
        end else if (wr_dat && busy) begin
            write_collision_flag_r <= 1'b1;
        end else if ((wr_dat && !busy) || (wr_sta && !WB_DAT_I[STA_WRITE_COLLISION_FLAG])) begin
            write_collision_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_fault_flag_r <= 1'b0;
        end else if (mode_fault_flag_evt) begin
            mode_fault_flag_r <= 1'b1;
        end else if (wr_sta && !WB_DAT_I[STA_MODE_FAULT_FLAG]) begin
            mode_fault_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ovr_r <= 1'b0;
        end else if (done_ev && full_r) begin
            ovr_r <= 1'b1;
        end else if (rd_dat || (wr_sta && !WB_DAT_I[STA_OVR])) begin
            ovr_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            full_r <= 1'b0;
        end else if (done_ev) begin
            full_r <= 1'b1;
        end else if (rd_dat || (wr_sta && !WB_DAT_I[STA_FULL])) begin
            full_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, clear and enable
    always_comb begin
        ist_set           = IRQ_RST;
        ist_set[IRQ_DONE] = done_ev;
        ist_set[IRQ_WRITE_COLLISION_FLAG] = wr_dat & busy;
        ist_set[IRQ_MODE_FAULT_FLAG] = mode_fault_flag_evt;
        ist_set[IRQ_OVR]  = done_ev & full_r;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ist_r <= IRQ_RST;
        end else if (wr_icl) begin
            ist_r <= (ist_r & ~WB_DAT_I[IRQ_W-1:0]) | ist_set;
        end else begin
            ist_r <= ist_r | ist_set;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ien_r <= IRQ_RST;
        end else if (wr_ien) begin
            ien_r <= WB_DAT_I[IRQ_W-1:0];
        end
    end

    // one cycle behind the status bit so IRQ is a clean flop output
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(ist_r & ien_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    AST_DISABLED_IDLE: assert property (!port_on |=> !busy)
        else $error("port busy while disabled");
    AST_SCK_IDLE: assert property (controller_select && !busy && !$past(busy) |-> SCK_O == $past(clock_idle_level))
        else $error("master sck not at idle level");
    AST_SAMPLE_EDGE: assert property (controller_select && sample_ev |=> (SCK_O != clock_idle_level) == !sample_edge_select)
        else $error("sample on wrong edge");
    AST_DIV_RATE: assert property (m_edge && !done_ev |=> div_cnt_r == 3'h0 && m_edge == (half_lim == 3'h0))
        else $error("sck half period wrong");
    AST_DONE_SET: assert property (done_ev |=> done_r && full_r && rxbuf_r == sr_r)
        else $error("done flag or buffer not updated");
    AST_VEC_CLEAR: assert property (VECTOR_ACK && !done_ev |=> !done_r)
        else $error("vector acknowledge did not clear done");
    AST_WRITE_COLLISION_FLAG_SET: assert property (wr_dat && busy && !done_ev |=> write_collision_flag_r && busy)
        else $error("collision not flagged");
    AST_WRITE_COLLISION_FLAG_CLR: assert property (wr_dat && !busy |=> !write_collision_flag_r)
        else $error("collision not cleared");
    AST_MODE_FAULT_FLAG: assert property (mode_fault_flag_evt |=> mode_fault_flag_r && !port_on && !controller_select)
        else $error("mode fault not handled");
    AST_MODE_FAULT_FLAG_CTL: assert property ($rose(mode_fault_flag_r) |-> !ctl_r[CTL_PORT_ON] && !ctl_r[CTL_CONTROLLER])
        else $error("control not cleared on mode fault");
    AST_OVR: assert property (done_ev && full_r |=> ovr_r && full_r)
        else $error("overrun not flagged");
    AST_FULL_READ: assert property (rd_dat && !done_ev |=> !full_r && !ovr_r ##1 WB_DAT_O[7:0] == $past(rxbuf_r, 2))
        else $error("data read did not clear flags");
    AST_START: assert property (wr_dat && !busy && port_on && controller_select |=> busy && sr_r == $past(WB_DAT_I[7:0]))
        else $error("master write did not start");
    AST_EIGHT_BITS: assert property (controller_select && $rose(busy) |-> ##[2:256] done_ev)
        else $error("master transfer did not finish");

    COV_MASTER_DONE: cover property (controller_select && done_ev);
    COV_SLAVE_DONE:  cover property (!controller_select && done_ev);
    COV_MODE_FAULT_FLAG:        cover property (mode_fault_flag_evt);
    COV_WRITE_COLLISION_FLAG:        cover property (wr_dat && busy);

endmodule

// ---- sps_pkg.sv ----
// sps_pkg: register indices, field positions, reset values and types of the spi port.
// assumes a 32-bit classic wishbone slave; byte address is four times a register index.
package sps_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clocking
    localparam int unsigned SYSTEM_CLOCK_FREQ_HZ = 100_000_000;

    ////////////////////////////////////////////////////////////////////////////
    // register indices (byte address = index * 4)
    localparam logic [7:0] IDX_PORT_CONTROL = 8'hBC;
    localparam logic [7:0] IDX_PORT_STATE   = 8'hBD;
    localparam logic [7:0] IDX_SHIFT_DATA   = 8'hBE;
    localparam logic [7:0] IDX_IRQ_STATUS   = 8'hC8;
    localparam logic [7:0] IDX_IRQ_CLEAR    = 8'hC9;
    localparam logic [7:0] IDX_IRQ_ENABLE   = 8'hCA;

    ////////////////////////////////////////////////////////////////////////////
    // port_control fields
    localparam int CTL_PORT_ON       = 7;
    localparam int CTL_CONTROLLER    = 6;
    localparam int CTL_IDLE_LEVEL    = 5;
    localparam int CTL_SAMPLE_EDGE   = 4;
    localparam int CTL_SELECT_IGNORE = 3;
    localparam int CTL_LOW_BIT_ORDER = 2;
    localparam int CTL_DIV_LSB       = 0;

    ////////////////////////////////////////////////////////////////////////////
    // port_state fields
    localparam int STA_DONE  = 7;
    localparam int STA_WRITE_COLLISION_FLAG  = 6;
    localparam int STA_MODE_FAULT_FLAG  = 5;
    localparam int STA_OVR   = 4;
    localparam int STA_FULL  = 3;
    localparam int STA_BUSY  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status / clear / enable fields
    localparam int IRQ_W        = 4;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_WRITE_COLLISION_FLAG     = 1;
    localparam int IRQ_MODE_FAULT_FLAG     = 2;
    localparam int IRQ_OVR      = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and counts
    localparam logic [7:0]       CTL_RST        = 8'h00;
    localparam logic [7:0]       DAT_RST        = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST        = 4'h0;
    localparam logic [3:0]       PIN_SYNC_RST   = 4'h8;
    localparam logic [3:0]       LAST_EDGE      = 4'hF;
    localparam logic [3:0]       LAST_SAMPLE    = 4'h7;

    typedef enum logic {SPS_IDLE, SPS_SHIFT} sps_state_e;

endpackage

// ---- sps_sync.sv ----
// sps_sync: three-stage input synchroniser with agreement filter.
// assumes asynchronous pins; q changes only once stages two and three agree.
`timescale 1ns/1ps
module sps_sync
    import sps_pkg::*;
#(
    parameter int         W    = 4,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    ////////////////////////////////////////////////////////////////////////////
    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= INIT;
        end else if (s2_r == s3_r) begin
            q <= s3_r;
        end
    end

endmodule

// ---- sps_spi_model.sv ----
// sps_spi_model: far-side spi slave for the port bench.
// assumes it is armed before each frame and the mode holds within a frame.
`timescale 1ns/1ps
module sps_spi_model (
    // pins
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // mode and data
    input  wire logic       idle_lvl,
    input  wire logic       phase,
    input  wire logic       lsb_first,
    input  wire logic       arm,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte
);
    int  k = 0;
    wire lead = sck ^ idle_lvl;
    initial miso = 1'b0;
    function automatic logic bit_at(input int i);
        return lsb_first ? tx_byte[i] : tx_byte[7-i];
    endfunction
    always @(posedge arm) begin
        k    = phase ? 0 : 1;
        // phase 1 shows noise until its first drive edge
        miso = phase ? ~bit_at(0) : bit_at(0);
    end
    always @(lead) begin
        if (lead ^ phase) begin
            rx_byte = lsb_first ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
        end else begin
            // past the eighth bit the line is not held
            miso = (k < 8) ? bit_at(k) : ~miso;
            k    = k + 1;
        end
    end
endmodule

// ---- sps_port_bench.sv ----
// sps_port_bench: self-checking bench of the spi port against a slave model.
// assumes one-cycle wishbone answer and the register map of sps_pkg.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module sps_port_bench;
    import sps_pkg::*;
    logic        CLK = 0, RST_N = 0, WB_WE_I = 0, WB_CYC_I = 0, WB_STB_I = 0;
    logic        VECTOR_ACK = 0, SS_N_I = 1, arm = 0, sck_b = 0, mosi_b = 0;
    logic [9:0]  WB_ADR_I = '0;
    logic [31:0] WB_DAT_I = '0, WB_DAT_O;
    logic [3:0]  WB_SEL_I = '0;
    logic        WB_ACK_O, SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE, IRQ, miso_m;
    logic [7:0]  ctl = '0, sb = '0, tx, rx_m, rd, so;
    logic [31:0] rnd = 32'h0000_0EE5;
    int          error_cnt = 0, check_count = 0, cyc = 0, hi_cnt = 0;
    wire         sck_w  = SCK_OE ? SCK_O : sck_b;
    wire         mosi_w = MOSI_OE ? MOSI_O : mosi_b;
    wire         miso_w = MISO_OE ? MISO_O : miso_m;
    ////////////////////////////////////////////////////////////////////////////
    sps_port u_sps_port (.CLK(CLK), .RST_N(RST_N), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
        .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SCK_I(sck_w), .SCK_O(SCK_O),
        .SCK_OE(SCK_OE), .MOSI_I(mosi_w), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE),
        .MISO_I(miso_w), .MISO_O(MISO_O), .MISO_OE(MISO_OE), .SS_N_I(SS_N_I),
        .VECTOR_ACK(VECTOR_ACK), .IRQ(IRQ));
    sps_spi_model u_sps_spi_model (.sck(sck_w), .mosi(mosi_w), .miso(miso_m),
        .idle_lvl(ctl[CTL_IDLE_LEVEL]), .phase(ctl[CTL_SAMPLE_EDGE]),
        .lsb_first(ctl[CTL_LOW_BIT_ORDER]), .arm(arm), .tx_byte(sb), .rx_byte(rx_m));
    ////////////////////////////////////////////////////////////////////////////
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (SCK_O !== ctl[CTL_IDLE_LEVEL]) hi_cnt <= hi_cnt + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // active sck cycles per frame: eight half periods of 2^div
    function automatic int sck_hi(input logic [1:0] d);
        return 8 << d;
    endfunction
    task automatic wb(input logic [7:0] idx, input logic we, input logic [7:0] wd);
        WB_ADR_I <= {idx, 2'b00};
        WB_WE_I  <= we;
        WB_DAT_I <= {24'h0, wd};
        WB_SEL_I <= 4'hF;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        do @(posedge CLK); while (WB_ACK_O !== 1'b1);
        rd = WB_DAT_O[7:0];
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic wait_idle();
        do wb(IDX_PORT_STATE, 1'b0, 8'h00); while (rd[STA_BUSY] !== 1'b0);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        // reset values, then an unmapped index that answers zero
        wb(IDX_PORT_CONTROL, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        wb(8'h10, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        // random frames, dividers 00..11 two each
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(lfsr(rnd));
            ctl = {2'b11, rnd[13:10], i[2:1]};
            tx  = rnd[23:16];
            sb  = rnd[31:24];
            wb(IDX_PORT_CONTROL, 1'b1, ctl);
            @(posedge CLK);
            `CHK(SCK_O, ctl[CTL_IDLE_LEVEL])
            hi_cnt <= 0;
            arm    <= 1'b1;
            wb(IDX_SHIFT_DATA, 1'b1, tx);
            arm    <= 1'b0;
            wb(IDX_PORT_STATE, 1'b0, 8'h00);
            `CHK(rd[STA_BUSY], 1'b1)
            wait_idle();
            `CHK(rd, (i % 4 == 2) ? 8'h98 : 8'h88)
            `CHK(hi_cnt, sck_hi(ctl[1:0]))
            `CHK(rx_m, tx)
            `CHK(IRQ, 1'b0)
            // frames 1 and 5 leave the byte unread to force an overrun
            if (i % 4 != 1) begin
                wb(IDX_SHIFT_DATA, 1'b0, 8'h00);
                // slow sck only: the pin path needs a few clocks of hold
                if (i > 5) `CHK(rd, sb)
                wb(IDX_PORT_STATE, 1'b0, 8'h00);
                `CHK(rd, 8'h80)
            end
            if (i[0]) begin
                VECTOR_ACK <= 1'b1;
                @(posedge CLK);
                VECTOR_ACK <= 1'b0;
            end else wb(IDX_PORT_STATE, 1'b1, 8'h7F);
            wb(IDX_PORT_STATE, 1'b0, 8'h00);
            `CHK(rd, (i % 4 == 1) ? 8'h08 : 8'h00)
        end
        // collision in mid-frame, then a clean write while idle
        ctl = 8'hC3;
        wb(IDX_PORT_CONTROL, 1'b1, ctl);
        arm <= 1'b1;
        wb(IDX_SHIFT_DATA, 1'b1, 8'hA5);
        arm <= 1'b0;
        wb(IDX_SHIFT_DATA, 1'b1, 8'h3C);
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h44)
        wait_idle();
        `CHK(rd, 8'hC8)
        `CHK(rx_m, 8'hA5)
        arm <= 1'b1;
        wb(IDX_SHIFT_DATA, 1'b1, 8'h5A);
        arm <= 1'b0;
        wait_idle();
        `CHK(rd, 8'h98)
        `CHK(rx_m, 8'h5A)
        wb(IDX_PORT_STATE, 1'b1, 8'h00);
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        // select pin pulled low while master
        wb(IDX_IRQ_CLEAR, 1'b1, 8'h0F);
        wb(IDX_PORT_CONTROL, 1'b1, 8'hC0);
        SS_N_I <= 1'b0;
        repeat (8) @(posedge CLK);
        `CHK(IRQ, 1'b0)
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h20)
        wb(IDX_PORT_CONTROL, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        wb(IDX_IRQ_STATUS, 1'b0, 8'h00);
        `CHK(rd, 8'h04)
        wb(IDX_IRQ_ENABLE, 1'b1, 8'h04);
        @(posedge CLK);
        `CHK(IRQ, 1'b1)
        wb(IDX_IRQ_CLEAR, 1'b1, 8'h04);
        @(posedge CLK);
        `CHK(IRQ, 1'b0)
        // select pin ignored, and a port that is off
        wb(IDX_PORT_STATE, 1'b1, 8'hDF);
        wb(IDX_PORT_CONTROL, 1'b1, 8'hC8);
        repeat (8) @(posedge CLK);
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        wb(IDX_PORT_CONTROL, 1'b1, 8'h48);
        wb(IDX_SHIFT_DATA, 1'b1, 8'hFF);
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h00)
        `CHK(SCK_OE, 1'b0)
        // slave frame, the bench clocking sck well below a quarter of CLK
        wb(IDX_IRQ_ENABLE, 1'b1, 8'h01);
        wb(IDX_PORT_CONTROL, 1'b1, 8'h88);
        wb(IDX_SHIFT_DATA, 1'b1, 8'hC6);
        `CHK(MISO_OE, 1'b1)
        `CHK(MOSI_OE, 1'b0)
        rnd = lfsr(rnd);
        for (int b = 7; b >= 0; b--) begin
            mosi_b <= rnd[b];
            so[b] = MISO_O;
            repeat (8) @(posedge CLK);
            sck_b <= 1'b1;
            repeat (8) @(posedge CLK);
            sck_b <= 1'b0;
            repeat (8) @(posedge CLK);
        end
        `CHK(so, 8'hC6)
        `CHK(IRQ, 1'b1)
        wb(IDX_PORT_STATE, 1'b0, 8'h00);
        `CHK(rd, 8'h88)
        wb(IDX_SHIFT_DATA, 1'b0, 8'h00);
        `CHK(rd, rnd[7:0])
        give_verdict();
    end
endmodule
